// ==== hw/driver_status_stall_logic.sv ====
// driver response status mapping, stall stop and current datagram filter
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "drv_stall_defines.svh"
// Summary of operation
// - step config bits 23:16 select which driver status bits feed the motor event
// - event bit 30 sets while any selected driver status bit is active
// - stop enabled, release clear, stall above threshold: ramp held at zero at once
// - each stall stop also sets the stall stop event flag
// - status bit 24 mirrors the returned driver stall bit directly
// - status bit 11 shows stall while absolute velocity exceeds threshold
// - reading the event register unlocks a latched stall stop
// - release bit set after unlock frees the ramp from the stall hold
// - format 1000 and 1001 are the two simple current-only driver families
// - cover length zero with known format picks length; 12 for simple formats
// - driver status byte updates from every complete response datagram
// - simple formats map eight flags to status bits 24 through 31 in order
// - simple formats send currents only when upper five bits of a coil change
// - microstep resolution affects simple formats only below 16
// - fullstep switch for simple formats depends only on ramp velocity
// - other formats take stall from one bit; load family compares three bits
module driver_status_stall_logic (
  // system
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // driver response link, foreign clock
  input wire logic i_link_sclk,
  input wire logic i_link_csn,
  input wire logic i_link_sdi,
  // ramp and current sources
  input wire logic [31:0] i_ramp_velocity_now,
  input wire logic [8:0] i_coil_a_current,
  input wire logic [8:0] i_coil_b_current,
  // control outputs
  output logic o_ramp_hold,
  output logic o_fullstep_active,
  output logic o_current_send,
  output logic [8:0] o_coil_a_current_out,
  output logic [8:0] o_coil_b_current_out,
  output logic o_interrupt_pin
);

  logic [31:0] ref_cfg_r;
  logic [31:0] link_cfg_r;
  logic [31:0] step_cfg_r;
  logic [31:0] vstall_r;
  logic [31:0] fsvel_r;
  logic [31:0] irq_en_r;
  logic [31:0] evt_r;
  logic [31:0] evt_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic csn_s1, csn_s2, csn_s3;
  logic sdi_s1, sdi_s2;
  drv_stall_pkg::link_state_t state_r;
  logic [39:0] shift_r;
  logic [6:0] bitcnt_r;
  logic [7:0] drv_status_r;
  logic stall_r;
  logic hold_r;
  logic unlock_r;
  logic fullstep_r;
  logic send_r;
  logic [8:0] cur_a_r;
  logic [8:0] cur_b_r;
  logic irq_r;

  // decode and transfer qualifiers
  logic [9:0] idx;
  logic setup;
  logic access;
  logic wr;
  logic rd_evt;
  logic hit;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign idx = i_paddr[11:2];
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable & pready_r;
  assign wr = access & i_pwrite;
  assign rd_evt = access & ~i_pwrite & (idx == `IDX_EVENTS);

  // format decode and response length
  drv_stall_pkg::fmt_t fmt;
  logic [6:0] cover_len;
  logic [6:0] exp_len;
  logic simple;

  assign fmt = drv_stall_pkg::fmt_t'(link_cfg_r[`LNK_FMT_MSB:`LNK_FMT_LSB]);
  assign cover_len = link_cfg_r[`LNK_COVER_MSB:`LNK_COVER_LSB];
  assign simple = (fmt == drv_stall_pkg::FMT_SIMPLE_A)
    || (fmt == drv_stall_pkg::FMT_SIMPLE_B);

  always_comb begin
    if (cover_len != 7'h00) begin
      exp_len = cover_len;
    end else begin
      case (fmt)
        drv_stall_pkg::FMT_SIMPLE_A,
        drv_stall_pkg::FMT_SIMPLE_B: exp_len = `LEN_SIMPLE;
        drv_stall_pkg::FMT_MID_SPI,
        drv_stall_pkg::FMT_MID_SD: exp_len = `LEN_MID;
        default: exp_len = `LEN_WIDE;
      endcase
    end
  end

  // velocity magnitude and stall decision
  logic [31:0] abs_v;
  logic over_thr;
  logic active_stall;
  logic stop_trig;
  logic [7:0] sel_hit;

  assign abs_v = i_ramp_velocity_now[31] ? 32'(-i_ramp_velocity_now) : i_ramp_velocity_now;
  assign over_thr = abs_v > vstall_r;
  assign active_stall = stall_r & over_thr;
  assign stop_trig = ref_cfg_r[`REF_STOP_EN] & ~ref_cfg_r[`REF_RELEASE]
    & active_stall;
  assign sel_hit = drv_status_r & step_cfg_r[`STEP_SEL_MSB:`STEP_SEL_LSB];

  // link input synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
      csn_s3 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= i_link_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      csn_s1 <= i_link_csn;
      csn_s2 <= csn_s1;
      csn_s3 <= csn_s2;
      sdi_s1 <= i_link_sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  logic sclk_rise;
  logic frame_end;
  logic rsp_done;

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign frame_end = (state_r == drv_stall_pkg::LINK_SHIFT) & csn_s2;
  // short or long frames are dropped so stale status is never half updated
  assign rsp_done = frame_end & (bitcnt_r == exp_len);

  // response receiver, msb first, sampled on driver clock rising edge
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= drv_stall_pkg::LINK_IDLE;
      shift_r <= 40'h00_0000_0000;
      bitcnt_r <= 7'h00;
    end else begin
      case (state_r)
        drv_stall_pkg::LINK_IDLE: begin
          if (~csn_s2 & csn_s3) begin
            state_r <= drv_stall_pkg::LINK_SHIFT;
            bitcnt_r <= 7'h00;
          end
        end
        drv_stall_pkg::LINK_SHIFT: begin
          if (csn_s2) begin
            state_r <= drv_stall_pkg::LINK_IDLE;
          end else if (sclk_rise) begin
            shift_r <= {shift_r[38:0], sdi_s2};
            if (bitcnt_r != 7'h7F) begin
              bitcnt_r <= bitcnt_r + 7'h01;
            end
          end
        end
        default: state_r <= drv_stall_pkg::LINK_IDLE;
      endcase
    end
  end

  // driver status byte and held stall bit
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      drv_status_r <= 8'h00;
      stall_r <= 1'b0;
    end else if (rsp_done) begin
      drv_status_r <= shift_r[7:0];
      case (fmt)
        drv_stall_pkg::FMT_SIMPLE_A: stall_r <= 1'b0;
        drv_stall_pkg::FMT_SIMPLE_B:
          stall_r <= (shift_r[10:8] <= link_cfg_r[`LNK_LOAD_MSB:`LNK_LOAD_LSB]);
        default: stall_r <= shift_r[0];
      endcase
    end
  end

  // stall stop hold and unlock
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hold_r <= 1'b0;
      unlock_r <= 1'b0;
    end else if (stop_trig) begin
      hold_r <= 1'b1;
      unlock_r <= 1'b0;
    end else if (hold_r & unlock_r & ref_cfg_r[`REF_RELEASE]) begin
      hold_r <= 1'b0;
      unlock_r <= 1'b0;
    end else if (rd_evt & hold_r) begin
      unlock_r <= 1'b1;
    end
  end

  // sticky events; a read clears only the bits it returned, a write to the clear register clears its set bits, set wins
  always_comb begin
    evt_nxt = evt_r;
    if (rd_evt) begin
      evt_nxt = evt_nxt & ~prdata_r;
    end
    if (wr & (idx == `IDX_EVT_CLR)) begin
      evt_nxt = evt_nxt & ~i_pwdata;
    end
    if (|sel_hit) begin
      evt_nxt[`EVT_MOTOR] = 1'b1;
    end
    if (stop_trig) begin
      evt_nxt[`EVT_STALL_STOP] = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      evt_r <= `RST_WORD;
      irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      irq_r <= |(evt_r & irq_en_r);
    end
  end

  // writable configuration; release bit only changes by software
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ref_cfg_r <= `RST_WORD;
      link_cfg_r <= `RST_WORD;
      step_cfg_r <= `RST_WORD;
      vstall_r <= `RST_WORD;
      fsvel_r <= `RST_WORD;
      irq_en_r <= `RST_WORD;
    end else if (wr) begin
      case (idx)
        `IDX_REF_CFG: ref_cfg_r <= i_pwdata;
        `IDX_LINK_CFG: link_cfg_r <= i_pwdata;
        `IDX_STEP_CFG: step_cfg_r <= i_pwdata;
        `IDX_VSTALL: vstall_r <= i_pwdata;
        `IDX_FS_VEL: fsvel_r <= i_pwdata;
        `IDX_IRQ_EN: irq_en_r <= i_pwdata;
        default: ;
      endcase
    end
  end

  // fullstep switch and current datagram filter
  logic coil_change;

  // only the upper five bits reach a simple driver, so finer resolutions
  // (16 and above) never trigger a datagram on their own
  assign coil_change = simple
    ? ((i_coil_a_current[8:4] != cur_a_r[8:4])
       || (i_coil_b_current[8:4] != cur_b_r[8:4]))
    : ((i_coil_a_current != cur_a_r) || (i_coil_b_current != cur_b_r));

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fullstep_r <= 1'b0;
    end else begin
      fullstep_r <= simple & (abs_v >= fsvel_r);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      send_r <= 1'b0;
      cur_a_r <= 9'h000;
      cur_b_r <= 9'h000;
    end else begin
      send_r <= (fmt != drv_stall_pkg::FMT_OFF) & coil_change;
      if ((fmt != drv_stall_pkg::FMT_OFF) & coil_change) begin
        cur_a_r <= i_coil_a_current;
        cur_b_r <= i_coil_b_current;
      end
    end
  end

  // read path
  always_comb begin
    status_word = `RST_WORD;
    status_word[31:`ST_DRV_LSB] = drv_status_r;
    status_word[`ST_ACTIVE_STALL] = active_stall;
    status_word[`ST_HOLD] = hold_r;
    status_word[`ST_FULLSTEP] = fullstep_r;
    hit = 1'b1;
    case (idx)
      `IDX_REF_CFG: rd_mux = ref_cfg_r;
      `IDX_LINK_CFG: rd_mux = link_cfg_r;
      `IDX_STEP_CFG: rd_mux = step_cfg_r;
      `IDX_EVENTS: rd_mux = evt_r;
      `IDX_STATUS: rd_mux = status_word;
      `IDX_FS_VEL: rd_mux = fsvel_r;
      `IDX_VSTALL: rd_mux = vstall_r;
      `IDX_IRQ_EN: rd_mux = irq_en_r;
      `IDX_EVT_CLR: rd_mux = `RST_WORD;
      `IDX_CURRENT: rd_mux = {7'h00, cur_b_r, 7'h00, cur_a_r};
      default: begin
        rd_mux = `RST_WORD;
        hit = 1'b0;
      end
    endcase
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `RST_WORD;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        prdata_r <= i_pwrite ? `RST_WORD : rd_mux;
      end
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_ramp_hold = hold_r;
  assign o_fullstep_active = fullstep_r;
  assign o_current_send = send_r;
  assign o_coil_a_current_out = cur_a_r;
  assign o_coil_b_current_out = cur_b_r;
  assign o_interrupt_pin = irq_r;

  a_motor_event_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (|sel_hit) |=> evt_r[`EVT_MOTOR])
    else $error("motor event not set");

  a_stall_hold_now: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    stop_trig |=> o_ramp_hold)
    else $error("stall stop did not hold ramp");

  a_stop_event_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    stop_trig |=> evt_r[`EVT_STALL_STOP] && o_ramp_hold)
    else $error("stall stop event missing");

  a_read_unlocks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_evt && hold_r && !stop_trig) |=> (unlock_r || !hold_r))
    else $error("event read did not unlock");

  a_release_frees: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (hold_r && unlock_r && ref_cfg_r[`REF_RELEASE] && !stop_trig) |=> !o_ramp_hold)
    else $error("release did not free ramp");

  a_status_capture: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rsp_done |=> drv_status_r == $past(shift_r[7:0]))
    else $error("status byte not captured");

  a_simple_len: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (frame_end && simple && cover_len == 7'h00 && bitcnt_r != 7'h0C)
    |=> $stable(drv_status_r))
    else $error("wrong length frame accepted");

  a_stall_bit_take: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rsp_done && !simple) |=> stall_r == $past(shift_r[0]))
    else $error("stall bit not taken");

  a_current_filter: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (simple && i_coil_a_current[8:4] == cur_a_r[8:4]
     && i_coil_b_current[8:4] == cur_b_r[8:4]) |=> !o_current_send)
    else $error("needless current datagram");

  a_fullstep_vel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (simple && abs_v >= fsvel_r) |=> o_fullstep_active)
    else $error("fullstep not active");

endmodule

// ==== include/drv_stall_defines.svh ====
// register map, field positions and lengths for driver status and stall logic
`ifndef DRV_STALL_DEFINES_SVH
`define DRV_STALL_DEFINES_SVH
// register indices; byte address is index times four
`define IDX_REF_CFG 10'h001
`define IDX_LINK_CFG 10'h004
`define IDX_STEP_CFG 10'h00A
`define IDX_EVENTS 10'h00E
`define IDX_STATUS 10'h00F
`define IDX_FS_VEL 10'h060
`define IDX_VSTALL 10'h067
`define IDX_IRQ_EN 10'h070
`define IDX_EVT_CLR 10'h071
`define IDX_CURRENT 10'h07B
// reference_switch_config fields
`define REF_STOP_EN 26
`define REF_RELEASE 27
// driver_link_config fields
`define LNK_FMT_MSB 3
`define LNK_FMT_LSB 0
`define LNK_LOAD_MSB 10
`define LNK_LOAD_LSB 8
`define LNK_COVER_MSB 19
`define LNK_COVER_LSB 13
// motor_step_config field
`define STEP_SEL_MSB 23
`define STEP_SEL_LSB 16
// event and status bits
`define EVT_STALL_STOP 12
`define EVT_MOTOR 30
`define ST_ACTIVE_STALL 11
`define ST_HOLD 13
`define ST_FULLSTEP 14
`define ST_DRV_LSB 24
// response lengths in bits
`define LEN_SIMPLE 7'h0C
`define LEN_MID 7'h14
`define LEN_WIDE 7'h28
// reset values
`define RST_WORD 32'h0000_0000
`endif

// ==== include/drv_stall_pkg.sv ====
// types for driver status and stall logic
package drv_stall_pkg;
  typedef enum logic [0:0] {
    LINK_IDLE = 1'b0,
    LINK_SHIFT = 1'b1
  } link_state_t;
  typedef enum logic [3:0] {
    FMT_OFF = 4'h0,
    FMT_SIMPLE_A = 4'h8,
    FMT_SIMPLE_B = 4'h9,
    FMT_MID_SPI = 4'hA,
    FMT_MID_SD = 4'hB,
    FMT_WIDE_SD = 4'hC,
    FMT_WIDE_SPI = 4'hD
  } fmt_t;
endpackage

// ==== verif/drv_resp_model.sv ====
// behavioural driver chip answering on the response link
`timescale 1ns/10ps
module drv_resp_model (
  // response link
  output logic o_sclk,
  output logic o_csn,
  output logic o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b0;
  end
  // msb first; a larger half period models a slow driver
  task automatic send(input int len, input logic [39:0] word, input realtime half);
    o_csn = 1'b0;
    for (int i = len - 1; i >= 0; i--) begin
      o_sdi = word[i];
      #(half) o_sclk = 1'b1;
      #(half) o_sclk = 1'b0;
    end
    #(half) o_csn = 1'b1;
    // released line has no pull: show the inverse, not a stale bit
    o_sdi = ~o_sdi;
  endtask
endmodule

// ==== verif/driver_status_stall_logic_bench.sv ====
// self-checking bench for driver status and stall logic
`timescale 1ns/10ps
`include "drv_stall_defines.svh"
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (w)); end end
module driver_status_stall_logic_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, vel = 32'h0000_0000;
  logic [8:0] cur_a = 9'h000, cur_b = 9'h000;
  logic [31:0] prdata, q, r, seed = 32'h7147FA4C;
  logic pready, pslverr, sclk, csn, sdi, hold, fs, send, irq, serr, sent;
  logic [8:0] out_a, out_b, ea, eb, na, nb;
  logic [9:0] regs [0:6] = '{`IDX_REF_CFG, `IDX_LINK_CFG, `IDX_STEP_CFG, `IDX_EVENTS,
    `IDX_STATUS, `IDX_VSTALL, `IDX_CURRENT};
  int errors = 0, checked = 0;
  always #2 clk = ~clk;
  driver_status_stall_logic dut_u (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_link_sclk(sclk),
    .i_link_csn(csn), .i_link_sdi(sdi), .i_ramp_velocity_now(vel),
    .i_coil_a_current(cur_a), .i_coil_b_current(cur_b), .o_ramp_hold(hold),
    .o_fullstep_active(fs), .o_current_send(send), .o_coil_a_current_out(out_a),
    .o_coil_b_current_out(out_b), .o_interrupt_pin(irq));
  drv_resp_model resp_u (.o_sclk(sclk), .o_csn(csn), .o_sdi(sdi));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // only the upper five bits of a coil count as a change
  function automatic logic moved(input logic [8:0] oa, ob, a, b);
    return (oa[8:4] != a[8:4]) || (ob[8:4] != b[8:4]);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input int len, input logic [39:0] w);
    resp_u.send(len, w, 62.5);
    cyc(8);
  endtask
  task automatic fsv(input logic [31:0] v);
    @(posedge clk);
    vel <= v;
    cyc(3);
  endtask
  task automatic results();
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    cyc(4);
    rst <= 1'b0;
    foreach (regs[k]) begin
      bus(1'b0, regs[k], 32'h0);
      `CHK(q, `RST_WORD)
    end
    bus(1'b1, `IDX_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, `IDX_STATUS, 32'h0);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, 10'h3FF, 32'h0);
    `CHK({serr, q}, 33'h1_0000_0000)
    for (int f = 8; f < 10; f++) begin
      bus(1'b1, `IDX_LINK_CFG, 32'(f));
      r = xs();
      frame(12, 40'(r[11:0]));
      bus(1'b0, `IDX_STATUS, 32'h0);
      `CHK(q[31:24], r[7:0])
      resp_u.send(13, 40'(~r[12:0]), 62.5);
      cyc(8);
      bus(1'b0, `IDX_STATUS, 32'h0);
      `CHK(q[31:24], r[7:0])
    end
    frame(12, 40'h710);
    bus(1'b1, `IDX_IRQ_EN, 32'h4000_0000);
    bus(1'b1, `IDX_STEP_CFG, 32'h00EF_0000);
    cyc(3);
    `CHK(irq, 1'b0)
    bus(1'b1, `IDX_STEP_CFG, 32'h0010_0000);
    cyc(3);
    `CHK(irq, 1'b1)
    bus(1'b1, `IDX_IRQ_EN, 32'h0);
    cyc(3);
    `CHK(irq, 1'b0)
    bus(1'b1, `IDX_IRQ_EN, 32'h4000_0000);
    bus(1'b0, `IDX_EVENTS, 32'h0);
    `CHK(q[30], 1'b1)
    bus(1'b1, `IDX_STEP_CFG, 32'h0);
    bus(1'b1, `IDX_EVT_CLR, 32'h4000_0000);
    cyc(3);
    `CHK(irq, 1'b0)
    bus(1'b1, `IDX_LINK_CFG, 32'h0000_0309);
    bus(1'b1, `IDX_VSTALL, 32'h0000_0064);
    bus(1'b1, `IDX_REF_CFG, 32'h0400_0000);
    fsv(32'hFFFF_FF38);
    frame(12, 40'h400);
    `CHK(hold, 1'b0)
    fsv(32'h0000_0064);
    frame(12, 40'h300);
    bus(1'b0, `IDX_STATUS, 32'h0);
    `CHK({hold, q[11]}, 2'b00)
    fsv(32'hFFFF_FF38);
    `CHK(hold, 1'b1)
    bus(1'b0, `IDX_STATUS, 32'h0);
    `CHK(q[11], 1'b1)
    bus(1'b1, `IDX_REF_CFG, 32'h0C00_0000);
    cyc(3);
    `CHK(hold, 1'b1)
    bus(1'b0, `IDX_EVENTS, 32'h0);
    `CHK(q[12], 1'b1)
    cyc(3);
    `CHK(hold, 1'b0)
    bus(1'b0, `IDX_REF_CFG, 32'h0);
    `CHK(q, 32'h0C00_0000)
    bus(1'b1, `IDX_REF_CFG, 32'h0);
    bus(1'b1, `IDX_LINK_CFG, 32'h0000_000A);
    frame(20, 40'h00001);
    bus(1'b0, `IDX_STATUS, 32'h0);
    `CHK({q[24], q[11]}, 2'b11)
    bus(1'b1, `IDX_LINK_CFG, 32'h0000_0008);
    bus(1'b1, `IDX_FS_VEL, 32'h7FFF_FFFF);
    cyc(3);
    ea = out_a;
    eb = out_b;
    for (int k = 0; k < 40; k++) begin
      r = xs();
      na = r[31] ? {ea[8:4], r[3:0]} : r[8:0];
      nb = r[30] ? {eb[8:4], r[7:4]} : r[24:16];
      @(posedge clk);
      cur_a <= na;
      cur_b <= nb;
      sent = 1'b0;
      repeat (3) begin
        @(posedge clk);
        #1 sent = sent | send;
      end
      `CHK(sent, moved(ea, eb, na, nb))
      if (moved(ea, eb, na, nb)) begin
        ea = na;
        eb = nb;
      end
      `CHK({out_a, out_b}, {ea, eb})
    end
    bus(1'b0, `IDX_CURRENT, 32'h0);
    `CHK(q, {7'h00, eb, 7'h00, ea})
    bus(1'b1, `IDX_FS_VEL, 32'h0000_01F4);
    fsv(32'h0000_0258);
    `CHK(fs, 1'b1)
    fsv(32'hFFFF_FE70);
    `CHK(fs, 1'b0)
    fsv(32'hFFFF_FE0C);
    `CHK(fs, 1'b1)
    results();
  end
endmodule
